/* phy_host_model.sv */
`default_nettype none
// ---------------------------------------------
// management host: classic wishbone master
// ---------------------------------------------
module phy_host_model (
    input wire logic clk_in,
    input wire logic ack_in,
    input wire logic [31:0] dat_in,
    output var logic cyc_out = 1'b0,
    output var logic stb_out = 1'b0,
    output var logic we_out = 1'b0,
    output var logic [7:0] adr_out = 8'h00,
    output var logic [3:0] sel_out = 4'h0,
    output var logic [31:0] dat_out = 32'h00000000
);
    timeunit 1ns;
    timeprecision 1ps;
    // one cycle, called just after a rising edge
    task automatic xfer(input logic we, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        cyc_out <= 1'b1;
        stb_out <= 1'b1;
        we_out <= we;
        adr_out <= a;
        sel_out <= 4'hF;
        dat_out <= d;
        // hold until ack is sampled high; a hang ends by timeout
        do begin
            @(posedge clk_in);
        end while (ack_in !== 1'b1);
        q = dat_in;
        // released address and data lines show no stale value; we and sel keep theirs
        cyc_out <= 1'b0;
        stb_out <= 1'b0;
        adr_out <= ~a;
        dat_out <= ~d;
        @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

/* phy_status_event_regs.sv */
`default_nettype none
// Notes on behaviour
// - bits 14,13 report autoneg, fiber; 15 zero
// - bit 12 recommended speed, 1 is 100M
// - bit 11 recommended duplex, 1 is full
// - bit 10 recommended pause, 1 enabled
// - bit 9 far-end fault, 1 is disabled
// - bit 8 crossover capable, bit 7 crossover state
// - bit 6 high when reduced/serial interface
// - bit 5 repeater role, bits 4:0 address
// - event bits 9,8,7 on changes; read clears
// - bits 6,5 page and link, held until read
// - bit 3 false carrier, high while link failed
// - bits 4,2,1,0 symbol, jabbers, delimiter error
// - 16-bit counter of receive error kinds

module phy_status_event_regs
    import phy_status_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic MCLK_IN,
    input wire logic RST_IN,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [ADR_W-1:0] WB_ADR_IN,
    input wire logic [BUS_DW/8-1:0] WB_SEL_IN,
    input wire logic [BUS_DW-1:0] WB_DAT_IN,
    output logic [BUS_DW-1:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    input wire straps_s STRAPS_IN,
    input wire line_s LINE_IN,
    output logic IRQ_OUT
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // counter must fit the register word
    if (CNT_W < 1 || CNT_W > REG_DW) begin : g_bad_cnt
        $error("CNT_W must lie between 1 and the register width");
    end

    // ------------------------------------------------------------
    // bus request decode
    // ------------------------------------------------------------
    wb_req_s req; // bundled request
    logic [IDX_W-1:0] req_idx; // word index
    logic req_live; // request waiting for an answer
    logic take; // request answered this edge
    logic rd_take; // read answered this edge
    logic wr_take; // write answered this edge
    logic lo_lane; // byte lane for bits 7:0
    logic hi_lane; // byte lane for bits 15:8
    logic [REG_DW-1:0] wr_mask; // bits reached by the write
    logic ack_q; // answer strobe
    logic ack_d; // next answer strobe

    assign req = '{
        cyc: WB_CYC_IN,
        stb: WB_STB_IN,
        we: WB_WE_IN,
        adr: WB_ADR_IN,
        sel: WB_SEL_IN,
        dat: WB_DAT_IN
    };

    // index is the byte address divided by four
    assign req_idx = req.adr[IDX_LSB +: IDX_W];
    assign req_live = req.cyc & req.stb;
    // answer one cycle after the request; drop after one
    assign ack_d = req_live & ~ack_q;
    // writes and read clears land on the edge that raises
    // ack; the master samples it one edge later
    assign take = ack_d;
    assign rd_take = take & ~req.we;
    assign wr_take = take & req.we;
    assign lo_lane = req.sel[0];
    assign hi_lane = req.sel[1];
    assign wr_mask = {{(REG_DW/2){hi_lane}}, {(REG_DW/2){lo_lane}}};

    // address hits
    // only the word index is decoded, low address bits ignored
    logic hit_rec; // recommended-value status
    logic hit_evt; // event status
    logic hit_cnt; // receive error counter
    logic hit_mask; // interrupt mask
    logic hit_pend; // interrupt pending

    assign hit_rec = (req_idx == IDX_REC_STATUS);
    assign hit_evt = (req_idx == IDX_EVENT);
    assign hit_cnt = (req_idx == IDX_ERR_COUNT);
    assign hit_mask = (req_idx == IDX_IRQ_MASK);
    assign hit_pend = (req_idx == IDX_IRQ_PEND);

    // ------------------------------------------------------------
    // settings capture
    // ------------------------------------------------------------
    // settings change only across a reset, so they are caught
    // in the first cycle after release and then frozen
    // a strap change without a reset stays invisible
    straps_s straps_q; // frozen settings
    logic caught_q; // settings have been caught

    // capture once after reset release
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            straps_q <= '0;
            caught_q <= 1'b0;
        end else if (!caught_q) begin
            straps_q <= STRAPS_IN;
            caught_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // recommended-value status word
    // ------------------------------------------------------------
    logic [REG_DW-1:0] rec_word; // assembled status word

    // place each setting at its field
    always_comb begin
        rec_word = REG_ZERO;
        rec_word[REC_RES_BIT] = 1'b0;
        rec_word[REC_AUTONEG_BIT] = straps_q.autoneg;
        rec_word[REC_FIBER_BIT] = straps_q.fiber;
        rec_word[REC_SPEED_BIT] = straps_q.speed;
        rec_word[REC_DUPLEX_BIT] = straps_q.duplex;
        rec_word[REC_PAUSE_BIT] = straps_q.pause;
        rec_word[REC_FEF_OFF_BIT] = straps_q.fef_off;
        rec_word[REC_XOVER_CAP_BIT] = straps_q.xover_cap;
        // crossover state is live, not frozen
        rec_word[REC_XOVER_STATE_BIT] = LINE_IN.xover_state;
        rec_word[REC_REDUCED_SERIAL_IF_USED_BIT] = straps_q.reduced_serial_if_used;
        rec_word[REC_REPEATER_BIT] = straps_q.repeater;
        rec_word[REC_ADDR_MSB -: REC_ADDR_W] = straps_q.addr;
    end

    // ------------------------------------------------------------
    // change detection on live status
    // ------------------------------------------------------------
    // previous values; compare only once they are valid so the
    // first cycle after reset raises no false change
    logic prev_xover_q; // last crossover state
    logic prev_speed_q; // last speed
    logic prev_duplex_q; // last duplex
    logic prev_link_q; // last link state
    logic prev_ok_q; // previous values valid

    // sample the live status each cycle
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            prev_xover_q <= 1'b0;
            prev_speed_q <= 1'b0;
            prev_duplex_q <= 1'b0;
            prev_link_q <= 1'b0;
            prev_ok_q <= 1'b0;
        end else begin
            prev_xover_q <= LINE_IN.xover_state;
            prev_speed_q <= LINE_IN.speed;
            prev_duplex_q <= LINE_IN.duplex;
            prev_link_q <= LINE_IN.link_up;
            prev_ok_q <= 1'b1;
        end
    end

    logic xover_chg; // crossover mode changed
    logic speed_chg; // speed changed
    logic duplex_chg; // duplex changed
    logic link_chg; // link state changed

    assign xover_chg = prev_ok_q & (prev_xover_q ^ LINE_IN.xover_state);
    assign speed_chg = prev_ok_q & (prev_speed_q ^ LINE_IN.speed);
    assign duplex_chg = prev_ok_q & (prev_duplex_q ^ LINE_IN.duplex);
    assign link_chg = prev_ok_q & (prev_link_q ^ LINE_IN.link_up);

    // ------------------------------------------------------------
    // event set vector
    // ------------------------------------------------------------
    logic [EVT_W-1:0] evt_set; // events seen this cycle

    // map each event to its flag
    always_comb begin
        evt_set = EVT_RESET;
        evt_set[EVT_XOVER_BIT] = xover_chg;
        evt_set[EVT_SPEED_BIT] = speed_chg;
        evt_set[EVT_DUPLEX_BIT] = duplex_chg;
        evt_set[EVT_PAGE_BIT] = LINE_IN.page_rx;
        evt_set[EVT_LINK_BIT] = link_chg;
        evt_set[EVT_SYMBOL_BIT] = LINE_IN.symbol_err;
        // a failed link keeps setting the flag every cycle,
        // so it reads high for as long as the failure lasts
        evt_set[EVT_FALSE_CARRIER_FLAG_BIT] = LINE_IN.false_carrier
            | LINE_IN.link_failed;
        evt_set[EVT_TX_JAB_BIT] = LINE_IN.tx_jabber;
        evt_set[EVT_RX_JAB_BIT] = LINE_IN.rx_jabber;
        evt_set[EVT_ESD_BIT] = LINE_IN.esd_err;
    end

    // ------------------------------------------------------------
    // event status, cleared by reading it
    // ------------------------------------------------------------
    logic [EVT_W-1:0] evt_flags; // held event flags
    logic [EVT_W-1:0] evt_clr; // clear on read

    // the whole register clears at the answering edge
    assign evt_clr = {EVT_W{rd_take & hit_evt}};

    // set wins, so an event in the read cycle stays for next
    sticky_flags #(
        .W(EVT_W)
    ) u_evt_flags (
        .clk_in(MCLK_IN),
        .rst_in(RST_IN),
        .set_in(evt_set),
        .clr_in(evt_clr),
        .flags_out(evt_flags)
    );

    // ------------------------------------------------------------
    // interrupt pending, cleared by writing ones
    // ------------------------------------------------------------
    logic [EVT_W-1:0] pend_flags; // held interrupt causes
    logic [EVT_W-1:0] pend_clr; // write-one-to-clear
    logic [EVT_W-1:0] irq_mask_q; // interrupt enables
    logic [EVT_W-1:0] wr_bits; // lane-gated write data

    assign wr_bits = req.dat[EVT_W-1:0] & wr_mask[EVT_W-1:0];
    assign pend_clr = (wr_take & hit_pend) ? wr_bits : EVT_RESET;

    // same events, independent of the clear-on-read copy
    // so reading event status leaves the interrupt alone
    sticky_flags #(
        .W(EVT_W)
    ) u_pend_flags (
        .clk_in(MCLK_IN),
        .rst_in(RST_IN),
        .set_in(evt_set),
        .clr_in(pend_clr),
        .flags_out(pend_flags)
    );

    // mask register, lanes honoured per bit
    // lanes left clear keep their old enable bits
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            irq_mask_q <= EVT_RESET;
        end else if (wr_take && hit_mask) begin
            irq_mask_q <= (irq_mask_q & ~wr_mask[EVT_W-1:0])
                | wr_bits;
        end
    end

    // level interrupt while any enabled cause is pending
    assign IRQ_OUT = |(pend_flags & irq_mask_q);

    // ------------------------------------------------------------
    // receive error counter
    // ------------------------------------------------------------
    logic [CNT_W-1:0] err_cnt_q; // error count
    logic [CNT_W-1:0] err_cnt_d; // next error count
    logic err_seen; // a counted error this cycle
    logic cnt_full; // counter at its top value

    // every counted receive error kind
    // several kinds in one cycle count only once
    assign err_seen = LINE_IN.false_carrier
        | LINE_IN.symbol_err
        | LINE_IN.tx_jabber
        | LINE_IN.rx_jabber
        | LINE_IN.ssd_err
        | LINE_IN.esd_err;
    // hold at the top instead of wrapping to zero
    assign cnt_full = &err_cnt_q;
    assign err_cnt_d = err_cnt_q + CNT_W'(1);

    // count one per cycle with any error
    // reading the count does not clear it
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            err_cnt_q <= '0;
        end else if (err_seen && !cnt_full) begin
            err_cnt_q <= err_cnt_d;
        end
    end

    // ------------------------------------------------------------
    // read data selection
    // ------------------------------------------------------------
    logic [REG_DW-1:0] rd_word; // selected register
    logic [REG_DW-1:0] evt_word; // event status widened
    logic [REG_DW-1:0] cnt_word; // counter widened
    logic [REG_DW-1:0] mask_word; // mask widened
    logic [REG_DW-1:0] pend_word; // pending widened

    // reserved upper bits read as zero
    assign evt_word = {{(REG_DW-EVT_W){1'b0}}, evt_flags};
    assign mask_word = {{(REG_DW-EVT_W){1'b0}}, irq_mask_q};
    assign pend_word = {{(REG_DW-EVT_W){1'b0}}, pend_flags};
    assign cnt_word = REG_DW'(err_cnt_q);

    // unmapped addresses read zero and still answer
    assign rd_word = hit_rec ? rec_word
        : hit_evt ? evt_word
        : hit_cnt ? cnt_word
        : hit_mask ? mask_word
        : hit_pend ? pend_word
        : REG_ZERO;

    // ------------------------------------------------------------
    // answer registers
    // ------------------------------------------------------------
    logic [BUS_DW-1:0] dat_q; // read data to the bus

    // strobe the answer for one cycle
    // a request held past ack sees ack low for a cycle
    // and is then taken again
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
        end
    end

    // latch read data with the answer
    // the word then holds until the next read
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            dat_q <= BUS_ZERO;
        end else if (rd_take) begin
            dat_q <= {{(BUS_DW-REG_DW){1'b0}}, rd_word};
        end
    end

    assign WB_ACK_OUT = ack_q;
    assign WB_DAT_OUT = dat_q;

endmodule
`default_nettype wire

/* phy_status_event_regs_test.sv */
`default_nettype none
// ---------------------------------------------
// self-checking bench for the phy status bank
// ---------------------------------------------
module phy_status_event_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    import phy_status_pkg::*;
    localparam int CNT_W_T = 4; // short counter, saturates early
    localparam int CNT_MAX = (1 << CNT_W_T) - 1;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    straps_s straps = straps_s'(14'h2AB5);
    line_s line = '0;
    wire logic cyc, stb, we, ack, irq;
    wire logic [7:0] adr;
    wire logic [3:0] sel;
    wire logic [31:0] wdat, rdat;
    int err_total = 0;
    int total_checks = 0;
    int cycles = 0;
    int exp_cnt = 0;
    logic [31:0] q;

    phy_status_event_regs #(.CNT_W(CNT_W_T)) i_dut (.MCLK_IN(mclk),
        .RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
        .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
        .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .STRAPS_IN(straps),
        .LINE_IN(line), .IRQ_OUT(irq));
    phy_host_model i_host (.clk_in(mclk), .ack_in(ack), .dat_in(rdat),
        .cyc_out(cyc), .stb_out(stb), .we_out(we), .adr_out(adr),
        .sel_out(sel), .dat_out(wdat));

    always #10 mclk = ~mclk;
    // hang guard
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk_word(string n, logic [31:0] e, logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", n, e, g);
            err_total++;
        end
    endtask
    task automatic chk_bit(string n, logic e, logic g);
        total_checks++;
        if (g !== e) begin
            $display("Error %s expected %b seen %b", n, e, g);
            err_total++;
        end
    endtask
    task automatic rd(logic [5:0] i);
        i_host.xfer(1'b0, {i, 2'b00}, 32'h00000000, q);
    endtask
    task automatic wr(logic [5:0] i, logic [31:0] d);
        i_host.xfer(1'b1, {i, 2'b00}, d, q);
    endtask
    task automatic do_reset(logic [13:0] s);
        straps <= straps_s'(s);
        line <= '0;
        rst <= 1'b1;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        exp_cnt = 0;
        repeat (2) @(posedge mclk);
    endtask
    task automatic t_reset_vals();
        logic [5:0] ix[4] = '{IDX_EVENT, IDX_ERR_COUNT, IDX_IRQ_MASK,
                              IDX_IRQ_PEND};
        foreach (ix[k]) begin
            rd(ix[k]);
            chk_word("reset value", 32'h00000000, q);
        end
        chk_bit("irq reset", 1'b0, irq);
    endtask
    // straps frozen after capture, crossover state live
    task automatic t_rec(logic [13:0] s);
        rd(IDX_REC_STATUS);
        chk_word("rec", {17'h0, s[13:7], 1'b0, s[6:0]}, q);
        straps <= straps_s'(~s);
        line.xover_state <= 1'b1;
        repeat (2) @(posedge mclk);
        rd(IDX_REC_STATUS);
        chk_word("rec live", {17'h0, s[13:7], 1'b1, s[6:0]}, q);
        line.xover_state <= 1'b0;
        repeat (2) @(posedge mclk);
        rd(IDX_EVENT);
        rd(IDX_EVENT);
    endtask
    // each pulse kind except ssd_err sets its flag, read clears, counter counts all but page_rx
    task automatic t_pulses();
        int eb[7] = '{0, -1, 1, 2, 3, 4, 6};
        for (int i = 0; i < 7; i++) begin
            line[i] <= 1'b1;
            @(posedge mclk);
            line[i] <= 1'b0;
            if (i < 6) exp_cnt++;
            rd(IDX_EVENT);
            chk_word("event", eb[i] < 0 ? 0 : 32'h1 << eb[i], q);
            rd(IDX_EVENT);
            chk_word("event cleared", 32'h0, q);
            rd(IDX_ERR_COUNT);
            chk_word("count", exp_cnt, q);
        end
    endtask
    task automatic t_levels();
        int lb[4] = '{8, 9, 10, 11};
        int eb[4] = '{5, 7, 8, 9};
        for (int k = 0; k < 4; k++) begin
            line[lb[k]] <= ~line[lb[k]];
            repeat (3) @(posedge mclk);
            rd(IDX_EVENT);
            chk_word("change", 32'h1 << eb[k], q);
            rd(IDX_EVENT);
            chk_word("change cleared", 32'h0, q);
        end
    endtask
    task automatic t_fail();
        line.link_failed <= 1'b1;
        repeat (2) @(posedge mclk);
        rd(IDX_EVENT);
        chk_word("fail", 32'h8, q);
        rd(IDX_EVENT);
        chk_word("fail held", 32'h8, q);
        line.link_failed <= 1'b0;
        @(posedge mclk);
        rd(IDX_EVENT);
        rd(IDX_EVENT);
        chk_word("fail gone", 32'h0, q);
    endtask
    // event in the cycle of a clearing read survives
    task automatic t_race();
        fork
            rd(IDX_EVENT);
            begin
                line.symbol_err <= 1'b1;
                @(posedge mclk);
                line.symbol_err <= 1'b0;
            end
        join
        chk_word("race first", 32'h0, q);
        exp_cnt++;
        rd(IDX_EVENT);
        chk_word("race", 32'h10, q);
    endtask
    task automatic t_irq();
        wr(IDX_IRQ_PEND, 32'h3FF);
        chk_bit("irq clear", 1'b0, irq);
        line.page_rx <= 1'b1;
        @(posedge mclk);
        line.page_rx <= 1'b0;
        repeat (2) @(posedge mclk);
        chk_bit("irq masked", 1'b0, irq);
        wr(IDX_IRQ_MASK, 32'h40);
        chk_bit("irq on", 1'b1, irq);
        rd(IDX_EVENT);
        chk_bit("irq after read", 1'b1, irq);
        wr(IDX_IRQ_PEND, 32'h40);
        chk_bit("irq off", 1'b0, irq);
        rd(IDX_IRQ_MASK);
        chk_word("mask", 32'h40, q);
        rd(6'h3F);
        chk_word("unmapped", 32'h0, q);
        wr(IDX_ERR_COUNT, 32'hFFFF);
        rd(IDX_ERR_COUNT);
        chk_word("count ro", exp_cnt, q);
    endtask
    task automatic t_sat();
        line.symbol_err <= 1'b1;
        repeat (12) @(posedge mclk);
        line.symbol_err <= 1'b0;
        @(posedge mclk);
        exp_cnt = exp_cnt + 12 > CNT_MAX ? CNT_MAX : exp_cnt + 12;
        rd(IDX_ERR_COUNT);
        chk_word("count sat", exp_cnt, q);
    endtask

    // main sequence, second reset in mid-run
    initial begin
        do_reset(14'h2AB5);
        t_reset_vals();
        t_rec(14'h2AB5);
        t_pulses();
        t_levels();
        t_fail();
        t_race();
        t_irq();
        t_sat();
        do_reset(14'h154A);
        t_reset_vals();
        t_rec(14'h154A);
        print_verdict();
    end
endmodule

bind phy_status_event_regs phy_status_monitor i_mon (.MCLK_IN(MCLK_IN),
    .RST_IN(RST_IN), .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN),
    .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN), .WB_DAT_OUT(WB_DAT_OUT),
    .WB_ACK_OUT(WB_ACK_OUT), .LINE_IN(LINE_IN), .IRQ_OUT(IRQ_OUT));
`default_nettype wire

/* phy_status_monitor.sv */
`default_nettype none
// ---------------------------------------------
// port checker for the phy status bank
// ---------------------------------------------
module phy_status_monitor
    import phy_status_pkg::*;
(
    input wire logic MCLK_IN,
    input wire logic RST_IN,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [ADR_W-1:0] WB_ADR_IN,
    input wire logic [BUS_DW-1:0] WB_DAT_OUT,
    input wire logic WB_ACK_OUT,
    input wire line_s LINE_IN,
    input wire logic IRQ_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    // request taken at this edge
    wire logic take = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
    wire logic rd_evt = take && !WB_WE_IN && WB_ADR_IN[7:2] == IDX_EVENT;
    wire logic rd_rec = take && !WB_WE_IN && WB_ADR_IN[7:2] == IDX_REC_STATUS;

    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (RST_IN);

    AST_ACK_ONE: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
        else $error("ack held too long");
    AST_ACK_TAKE: assert property (take |=> WB_ACK_OUT)
        else $error("ack missing after request");
    AST_ACK_IDLE: assert property (!(WB_CYC_IN && WB_STB_IN) |=> !WB_ACK_OUT)
        else $error("ack without request");
    AST_DAT_HIGH: assert property (WB_ACK_OUT |-> WB_DAT_OUT[31:16] == 16'h0000)
        else $error("upper read half not zero");
    AST_REC_RES: assert property (rd_rec |=> !WB_DAT_OUT[REC_RES_BIT])
        else $error("reserved status bit set");
    AST_EVT_RES: assert property (rd_evt |=> WB_DAT_OUT[15:10] == 6'h00)
        else $error("reserved event bits set");
    AST_PAGE: assert property (rd_evt && $past(LINE_IN.page_rx)
        |=> WB_DAT_OUT[EVT_PAGE_BIT]) else $error("page flag lost");
    AST_SYMBOL: assert property (rd_evt && $past(LINE_IN.symbol_err)
        |=> WB_DAT_OUT[EVT_SYMBOL_BIT]) else $error("symbol flag lost");
    AST_FALSE_CARRIER_FLAG: assert property (rd_evt && $past(LINE_IN.link_failed)
        |=> WB_DAT_OUT[EVT_FALSE_CARRIER_FLAG_BIT]) else $error("fail flag lost");
    // interrupt only drops after a register write
    AST_IRQ_FALL: assert property ($fell(IRQ_OUT)
        |-> $past(WB_CYC_IN) && $past(WB_STB_IN) && $past(WB_WE_IN))
        else $error("interrupt dropped without write");
endmodule
`default_nettype wire

/* phy_status_pkg.sv */
`default_nettype none
// ----------------------------------------------------------------
// shared constants and types for the phy status register bank
// ----------------------------------------------------------------
package phy_status_pkg;

    // register data width and word index decode
    localparam int REG_DW = 16;
    localparam int BUS_DW = 32;
    localparam int ADR_W = 8;
    localparam int IDX_W = 6;
    localparam int IDX_LSB = 2;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_REC_STATUS = 6'h18;
    localparam logic [IDX_W-1:0] IDX_EVENT = 6'h19;
    localparam logic [IDX_W-1:0] IDX_ERR_COUNT = 6'h1D;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 6'h20;
    localparam logic [IDX_W-1:0] IDX_IRQ_PEND = 6'h21;

    // ------------------------------------------------------------
    // recommended-value status field positions
    // ------------------------------------------------------------
    localparam int REC_RES_BIT = 15;
    localparam int REC_AUTONEG_BIT = 14;
    localparam int REC_FIBER_BIT = 13;
    localparam int REC_SPEED_BIT = 12;
    localparam int REC_DUPLEX_BIT = 11;
    localparam int REC_PAUSE_BIT = 10;
    localparam int REC_FEF_OFF_BIT = 9;
    localparam int REC_XOVER_CAP_BIT = 8;
    localparam int REC_XOVER_STATE_BIT = 7;
    localparam int REC_REDUCED_SERIAL_IF_USED_BIT = 6;
    localparam int REC_REPEATER_BIT = 5;
    localparam int REC_ADDR_MSB = 4;
    localparam int REC_ADDR_W = 5;

    // ------------------------------------------------------------
    // event status field positions
    // ------------------------------------------------------------
    localparam int EVT_W = 10;
    localparam int EVT_XOVER_BIT = 9;
    localparam int EVT_SPEED_BIT = 8;
    localparam int EVT_DUPLEX_BIT = 7;
    localparam int EVT_PAGE_BIT = 6;
    localparam int EVT_LINK_BIT = 5;
    localparam int EVT_SYMBOL_BIT = 4;
    localparam int EVT_FALSE_CARRIER_FLAG_BIT = 3;
    localparam int EVT_TX_JAB_BIT = 2;
    localparam int EVT_RX_JAB_BIT = 1;
    localparam int EVT_ESD_BIT = 0;

    // reset values
    localparam logic [EVT_W-1:0] EVT_RESET = 10'h000;
    localparam logic [REG_DW-1:0] REG_ZERO = 16'h0000;
    localparam logic [BUS_DW-1:0] BUS_ZERO = 32'h00000000;

    // settings caught once after reset
    typedef struct packed {
        logic autoneg;
        logic fiber;
        logic speed;
        logic duplex;
        logic pause;
        logic fef_off;
        logic xover_cap;
        logic reduced_serial_if_used;
        logic repeater;
        logic [REC_ADDR_W-1:0] addr;
    } straps_s;

    // live line-side status and event strobes
    typedef struct packed {
        logic xover_state;
        logic speed;
        logic duplex;
        logic link_up;
        logic link_failed;
        logic page_rx;
        logic symbol_err;
        logic false_carrier;
        logic tx_jabber;
        logic rx_jabber;
        logic ssd_err;
        logic esd_err;
    } line_s;

    // one wishbone request as seen by the slave
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [ADR_W-1:0] adr;
        logic [BUS_DW/8-1:0] sel;
        logic [BUS_DW-1:0] dat;
    } wb_req_s;

endpackage
`default_nettype wire

/* sticky_flags.sv */
`default_nettype none
// ----------------------------------------------------------------
// bank of sticky flags, set wins over clear
// ----------------------------------------------------------------
module sticky_flags #(
    parameter int W = 10
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [W-1:0] set_in,
    input wire logic [W-1:0] clr_in,
    output logic [W-1:0] flags_out
);

    logic [W-1:0] flags_q; // held flags
    logic [W-1:0] flags_d; // next flags

    // a set arriving with its clear keeps the flag
    assign flags_d = set_in | (flags_q & ~clr_in);
    assign flags_out = flags_q;

    // flag storage
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end

endmodule
`default_nettype wire
